/* sbcio_defs.svh */
/*
  Constants of the interrupt output block: timing, register offsets,
  field positions and reset values. Assumes a 125 MHz system clock.

*/
`ifndef SBCIO_DEFS_SVH
`define SBCIO_DEFS_SVH

`define SBCIO_CLK_NS 8
`define SBCIO_PULSE_NS 100000
`define SBCIO_GAP_NS 100000
`define SBCIO_CFG_FILT_NS 10000
`define SBCIO_PULSE_CYC (`SBCIO_PULSE_NS / `SBCIO_CLK_NS)
`define SBCIO_GAP_CYC \
  ((`SBCIO_GAP_NS + `SBCIO_CLK_NS - 1) / `SBCIO_CLK_NS)
`define SBCIO_CFG_CYC (`SBCIO_CFG_FILT_NS / `SBCIO_CLK_NS)

`define SBCIO_WAKE_W 8
`define SBCIO_FAIL_W 16
`define SBCIO_LVL_W 16
// Failure bits 4..0 are the restart-class errors and never interrupt.
`define SBCIO_FAIL_IRQ_CAP 16'hffe0

`define SBCIO_OFS_CTRL 8'h00
`define SBCIO_OFS_WAKE_EN 8'h04
`define SBCIO_OFS_WAKE_STAT 8'h08
`define SBCIO_OFS_FAIL_STAT 8'h0c
`define SBCIO_OFS_LEVEL 8'h10
`define SBCIO_OFS_CFG 8'h14
`define SBCIO_OFS_IRQ_STAT 8'h18
`define SBCIO_OFS_IRQ_MASK 8'h1c
`define SBCIO_OFS_PEND 8'h20

`define SBCIO_CTRL_GLOBAL_BIT 0
`define SBCIO_CTRL_RST 1'h0
`define SBCIO_WAKE_EN_RST 16'h0000
`define SBCIO_IRQ_MASK_RST 3'h0
`define SBCIO_IRQ_PULSE_BIT 0
`define SBCIO_IRQ_CFG_BIT 1
`define SBCIO_IRQ_STOP_BIT 2
`define SBCIO_IRQ_W 3

`endif

/* sbcio_pkg.sv */
/*
  Types of the interrupt output block. Needs no other file.
*/
package sbcio_pkg;

  typedef enum logic [3:0] {
    SBCIO_MODE_INIT = 4'h1,
    SBCIO_MODE_NORMAL = 4'h2,
    SBCIO_MODE_STOP = 4'h4,
    SBCIO_MODE_OTHER = 4'h8
  } sbcio_mode_e;

  typedef enum logic [2:0] {
    SBCIO_ST_IDLE = 3'h1,
    SBCIO_ST_PULSE = 3'h2,
    SBCIO_ST_GAP = 3'h4
  } sbcio_state_e;

  typedef struct packed {
    logic [15:0] fail;
    logic [7:0] wake_b;
    logic [7:0] wake_a;
  } sbcio_evt_s;

endpackage : sbcio_pkg

/* sbcio_pulse_gen.sv */
/*
  Pulse and gap timer for the active-low interrupt line.
  Assumes req_i and allow_i are synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module sbcio_pulse_gen #(
  parameter int unsigned PULSE_CYC = 12500,
  parameter int unsigned GAP_CYC = 12500
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic allow_i,
  output logic start_o,
  output logic int_n_o
);
  localparam int unsigned CW = $clog2(PULSE_CYC + GAP_CYC + 1);
  localparam logic [CW-1:0] PULSE_END = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] GAP_END = CW'(GAP_CYC - 1);

  sbcio_pkg::sbcio_state_e st_q;
  logic [CW-1:0] cnt_q;

  // A request waiting during pulse or gap starts the next pulse. It may
  // start on the last gap cycle, so the high time is exactly GAP_CYC.
  assign start_o = ((st_q == sbcio_pkg::SBCIO_ST_IDLE) |
                    ((st_q == sbcio_pkg::SBCIO_ST_GAP) &
                     (cnt_q == GAP_END))) & req_i & allow_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= sbcio_pkg::SBCIO_ST_IDLE;
      cnt_q <= '0;
      int_n_o <= 1'b1;
    end else begin
      case (st_q)
        sbcio_pkg::SBCIO_ST_IDLE: begin
          cnt_q <= '0;
          if (start_o) begin
            st_q <= sbcio_pkg::SBCIO_ST_PULSE;
            int_n_o <= 1'b0;
          end
        end
        sbcio_pkg::SBCIO_ST_PULSE: begin
          if (cnt_q == PULSE_END) begin
            st_q <= sbcio_pkg::SBCIO_ST_GAP;
            cnt_q <= '0;
            int_n_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        sbcio_pkg::SBCIO_ST_GAP: begin
          if (cnt_q == GAP_END) begin
            cnt_q <= '0;
            if (start_o) begin
              st_q <= sbcio_pkg::SBCIO_ST_PULSE;
              int_n_o <= 1'b0;
            end else begin
              st_q <= sbcio_pkg::SBCIO_ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        default: begin
          st_q <= sbcio_pkg::SBCIO_ST_IDLE;
          cnt_q <= '0;
          int_n_o <= 1'b1;
        end
      endcase
    end
  end

endmodule : sbcio_pulse_gen

/* sbcio_cfg_filter.sv */
/*
  Stability filter for the configuration level on the interrupt pin.
  Assumes pin_i is synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module sbcio_cfg_filter #(
  parameter int unsigned FILT_CYC = 1250
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sample_en_i,
  input wire logic pin_i,
  output logic level_o,
  output logic valid_o
);
  localparam int unsigned CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_END = CW'(FILT_CYC - 1);

  logic cand_q;
  logic [CW-1:0] cnt_q;

  // The count restarts on every change, so short glitches never land.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cand_q <= 1'b0;
      cnt_q <= '0;
    end else if (!sample_en_i || pin_i != cand_q) begin
      cand_q <= pin_i;
      cnt_q <= '0;
    end else if (cnt_q != FILT_END) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      valid_o <= 1'b0;
    end else if (sample_en_i && pin_i == cand_q &&
                 cnt_q == FILT_END) begin
      level_o <= cand_q;
      valid_o <= 1'b1;
    end
  end

endmodule : sbcio_cfg_filter

/* sbcio_int_top.sv */
/*
  Interrupt output block: event latching, status commit, interrupt
  pulse line, configuration sampling and an Avalon-MM register slave.
  Assumes all inputs are synchronous to sys_clk_i and that the mode
  and stop command come from the device mode controller.
*/
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`include "sbcio_defs.svh"
`timescale 1ns/1ps
module sbcio_int_top #(
  parameter int unsigned PULSE_CYC = `SBCIO_PULSE_CYC,
  parameter int unsigned GAP_CYC = `SBCIO_GAP_CYC,
  parameter int unsigned CFG_CYC = `SBCIO_CFG_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input sbcio_pkg::sbcio_mode_e mode_i,
  input wire logic stop_cmd_i,
  input sbcio_pkg::sbcio_evt_s evt_i,
  input wire logic [`SBCIO_LVL_W-1:0] level_i,
  input wire logic int_pin_i,
  output logic int_n_o,
  output logic int_oe_o,
  output logic cfg_o,
  output logic cfg_valid_o,
  output logic irq_o
);
  localparam int unsigned EW = $bits(sbcio_pkg::sbcio_evt_s);
  localparam int unsigned WW = `SBCIO_WAKE_W;
  localparam int unsigned FW = `SBCIO_FAIL_W;
  localparam int unsigned IW = `SBCIO_IRQ_W;

  // Bus handshake and register state.
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic global_q;
  logic [2*WW-1:0] wake_en_q;
  logic [IW-1:0] irq_stat_q;
  logic [IW-1:0] irq_mask_q;

  // Event state: live holds every latched event, vis what the status registers show.
  logic [EW-1:0] live_q;
  logic [EW-1:0] vis_q;
  logic stop_req_q;
  logic cfg_valid_prev_q;
  logic int_oe_q;
  logic irq_q;

  logic req_take;
  logic wr_en;
  logic [EW-1:0] clr;
  logic [EW-1:0] cap;
  logic [EW-1:0] live_d;
  logic wake_left;
  logic fresh;
  logic allow;
  logic start;
  logic cfg_lvl;
  logic cfg_vld;
  logic [IW-1:0] irq_set;
  logic [IW-1:0] irq_clr;
  logic [31:0] rd_mux;

  // Avalon slave: one wait state, then the access completes.
  assign req_take = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_en = avs_write_i & ack_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= req_take;
      wait_q <= ~req_take;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `SBCIO_OFS_CTRL: rd_mux[`SBCIO_CTRL_GLOBAL_BIT] = global_q;
      `SBCIO_OFS_WAKE_EN: rd_mux[2*WW-1:0] = wake_en_q;
      `SBCIO_OFS_WAKE_STAT: rd_mux[2*WW-1:0] = vis_q[2*WW-1:0];
      `SBCIO_OFS_FAIL_STAT: rd_mux[FW-1:0] = vis_q[EW-1:2*WW];
      `SBCIO_OFS_LEVEL: rd_mux[`SBCIO_LVL_W-1:0] = level_i;
      `SBCIO_OFS_CFG: rd_mux[1:0] = {cfg_vld, cfg_lvl};
      `SBCIO_OFS_IRQ_STAT: rd_mux[IW-1:0] = irq_stat_q;
      `SBCIO_OFS_IRQ_MASK: rd_mux[IW-1:0] = irq_mask_q;
      `SBCIO_OFS_PEND: rd_mux[EW-1:0] = live_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req_take && avs_read_i) begin
      rdata_q <= rd_mux;
    end
  end

  // Control registers written by software.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      global_q <= `SBCIO_CTRL_RST;
      wake_en_q <= `SBCIO_WAKE_EN_RST;
      irq_mask_q <= `SBCIO_IRQ_MASK_RST;
    end else if (wr_en) begin
      case (avs_address_i)
        `SBCIO_OFS_CTRL:
          global_q <= avs_writedata_i[`SBCIO_CTRL_GLOBAL_BIT];
        `SBCIO_OFS_WAKE_EN: wake_en_q <= avs_writedata_i[2*WW-1:0];
        `SBCIO_OFS_IRQ_MASK: irq_mask_q <= avs_writedata_i[IW-1:0];
        default: ;
      endcase
    end
  end

  // Write-one-to-clear masks for the readable status registers.
  always_comb begin
    clr = '0;
    irq_clr = '0;
    if (wr_en) begin
      case (avs_address_i)
        `SBCIO_OFS_WAKE_STAT:
          clr[2*WW-1:0] = avs_writedata_i[2*WW-1:0];
        `SBCIO_OFS_FAIL_STAT:
          clr[EW-1:2*WW] = avs_writedata_i[FW-1:0];
        `SBCIO_OFS_IRQ_STAT: irq_clr = avs_writedata_i[IW-1:0];
        default: ;
      endcase
    end
  end

  // Which latched bits may raise a pulse. The level inputs are never
  // latched here, so they cannot interrupt.
  assign cap[2*WW-1:0] = wake_en_q;
  assign cap[EW-1:2*WW] = global_q ?
    FW'(`SBCIO_FAIL_IRQ_CAP) : '0;

  // Events latch whatever the class; a new event wins over a clear.
  assign live_d = (live_q & ~clr) | evt_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      live_q <= '0;
    end else begin
      live_q <= live_d;
    end
  end

  // Readable copy only changes at the pulse falling edge, apart from
  // host clears; events caught later stay pending in live_q.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vis_q <= '0;
    end else if (start) begin
      vis_q <= live_q & ~clr;
    end else begin
      vis_q <= vis_q & ~clr;
    end
  end

  // A capable event not yet shown to the host asks for a pulse.
  assign fresh = |(live_q & ~vis_q & cap);
  assign wake_left = |live_q[2*WW-1:0] | |vis_q[2*WW-1:0];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stop_req_q <= 1'b0;
    end else if (stop_cmd_i && wake_left) begin
      stop_req_q <= 1'b1;
    end else if (start) begin
      stop_req_q <= 1'b0;
    end
  end

  // Pulses only in Normal and Stop. The mode is only observed here,
  // never driven, so a pulse cannot move the device to another mode.
  assign allow = (mode_i == sbcio_pkg::SBCIO_MODE_NORMAL) |
                 (mode_i == sbcio_pkg::SBCIO_MODE_STOP);

  sbcio_pulse_gen #(
    .PULSE_CYC(PULSE_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_pulse (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .req_i(fresh | stop_req_q),
    .allow_i(allow),
    .start_o(start),
    .int_n_o(int_n_o)
  );

  // In init the driver is off so the external level and the pull-down
  // set the pin; the filter then decides the configuration.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_oe_q <= 1'b0;
    end else begin
      int_oe_q <= (mode_i != sbcio_pkg::SBCIO_MODE_INIT);
    end
  end

  sbcio_cfg_filter #(
    .FILT_CYC(CFG_CYC)
  ) u_cfg (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sample_en_i(mode_i == sbcio_pkg::SBCIO_MODE_INIT),
    .pin_i(int_pin_i),
    .level_o(cfg_lvl),
    .valid_o(cfg_vld)
  );

  // Block interrupt: pulse issued, configuration taken, stop refused
  // to pass silently. Set wins over a write-one clear.
  always_comb begin
    irq_set = '0;
    irq_set[`SBCIO_IRQ_PULSE_BIT] = start;
    irq_set[`SBCIO_IRQ_CFG_BIT] = cfg_vld & ~cfg_valid_prev_q;
    irq_set[`SBCIO_IRQ_STOP_BIT] = stop_cmd_i & wake_left;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      cfg_valid_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      cfg_valid_prev_q <= cfg_vld;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign int_oe_o = int_oe_q;
  assign cfg_o = cfg_lvl;
  assign cfg_valid_o = cfg_vld;
  assign irq_o = irq_q;

endmodule : sbcio_int_top

/* sbcio_int_top_properties.sv */
/*
  Checker for the interrupt output block: pulse, gap, pin and bus timing.
  Assumes it is bound to sbcio_int_top and sees only its ports.
*/
`timescale 1ns/1ps
module sbcio_int_top_properties #(
  parameter int unsigned PULSE_CYC = 12500,
  parameter int unsigned GAP_CYC = 12500,
  parameter int unsigned CFG_CYC = 1250
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input sbcio_pkg::sbcio_mode_e mode_i,
  input wire logic int_pin_i,
  input wire logic int_n_o,
  input wire logic int_oe_o,
  input wire logic cfg_o,
  input wire logic cfg_valid_o,
  input wire logic irq_o
);
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  logic [31:0] st_q;
  logic pin_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // The gap count starts full so a first pulse soon after reset is legal.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lo_q <= '0;
      hi_q <= GAP_CYC;
    end else if (!int_n_o) begin
      lo_q <= lo_q + 1;
      hi_q <= '0;
    end else begin
      lo_q <= '0;
      if (hi_q < GAP_CYC) hi_q <= hi_q + 1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    pin_q <= int_pin_i;
    if (rst_i || int_pin_i != pin_q) st_q <= '0;
    else st_q <= st_q + 1;
  end

  a_pulse_width: assert property ($rose(int_n_o) |-> lo_q == PULSE_CYC)
    else $error("pulse width wrong");
  a_pulse_bound: assert property (!int_n_o |-> lo_q < PULSE_CYC)
    else $error("pulse too long");
  a_gap_min: assert property ($fell(int_n_o) |-> hi_q >= GAP_CYC)
    else $error("gap too short");
  a_pulse_mode: assert property ($fell(int_n_o) |-> $past(mode_i) inside
    {sbcio_pkg::SBCIO_MODE_NORMAL, sbcio_pkg::SBCIO_MODE_STOP})
    else $error("pulse outside normal or stop");
  a_low_driven: assert property (!int_n_o |-> int_oe_o)
    else $error("low level not driven");
  a_init_release: assert property
    (mode_i == sbcio_pkg::SBCIO_MODE_INIT |=> !int_oe_o)
    else $error("pin driven in init");
  a_cfg_filter: assert property (($rose(cfg_valid_o) || $changed(cfg_o))
    |-> cfg_o == pin_q && st_q + 2 >= CFG_CYC)
    else $error("configuration taken unfiltered");
  a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_bus_answer: assert property
    ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("bus answer late");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");

  c_pulse: cover property ($fell(int_n_o));
  c_irq: cover property ($rose(irq_o));
  c_cfg: cover property ($rose(cfg_valid_o));
endmodule : sbcio_int_top_properties

bind sbcio_int_top sbcio_int_top_properties #(.PULSE_CYC(PULSE_CYC),
  .GAP_CYC(GAP_CYC), .CFG_CYC(CFG_CYC)) u_props (.*);

/* sbcio_host_model.sv */
/*
  Host side of the interrupt pin: strap level and pulse measurement.
  Assumes the block drives the pin push/pull while its enable is high.
*/
`timescale 1ns/1ps
module sbcio_host_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic int_n_i,
  input wire logic int_oe_i,
  input wire logic cfg_lvl_i,
  output logic pin_o,
  output logic [7:0] pulse_cnt_o,
  output logic [15:0] low_len_o,
  output logic [15:0] gap_len_o
);
  logic [15:0] run_q;
  logic last_q;

  // Released pin settles at the strap level; the strap is low by default.
  assign pin_o = (int_oe_i === 1'b1) ? int_n_i : cfg_lvl_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      last_q <= 1'b1;
      run_q <= 16'h0;
      pulse_cnt_o <= 8'h0;
      low_len_o <= 16'h0;
      gap_len_o <= 16'h0;
    end else if (pin_o != last_q) begin
      last_q <= pin_o;
      run_q <= 16'h1;
      if (pin_o) begin
        low_len_o <= run_q;
      end else if (int_oe_i) begin
        gap_len_o <= run_q;
        pulse_cnt_o <= pulse_cnt_o + 8'h1;
      end
    end else begin
      run_q <= run_q + 16'h1;
    end
  end
endmodule : sbcio_host_model

/* sbcio_int_top_tb.sv */
/*
  Self-checking bench for the interrupt output block.
  Assumes short pulse, gap and filter counts of 8, 8 and 4 cycles.
*/
`timescale 1ns/1ps
module sbcio_int_top_tb;
  localparam int PW = 8;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic stop_cmd_i = 0;
  logic strap = 0;
  logic [7:0] avs_address_i = 8'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [15:0] level_i = 16'h0;
  sbcio_pkg::sbcio_mode_e mode_i = sbcio_pkg::SBCIO_MODE_INIT;
  sbcio_pkg::sbcio_evt_s evt_i = '0;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, int_pin_i, int_n_o, int_oe_o;
  logic cfg_o, cfg_valid_o, irq_o;
  logic [7:0] npulse, n0;
  logic [15:0] low_len, gap_len;
  int err_total = 0;
  int tests_run = 0;

  sbcio_int_top #(.PULSE_CYC(PW), .GAP_CYC(PW), .CFG_CYC(4)) u_dut (.*);

  sbcio_host_model u_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .int_n_i(int_n_o), .int_oe_i(int_oe_o), .cfg_lvl_i(strap),
    .pin_o(int_pin_i), .pulse_cnt_o(npulse), .low_len_o(low_len),
    .gap_len_o(gap_len));

  always #4 sys_clk_i = ~sys_clk_i;

  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= d;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdchk

  task automatic ev(input logic [31:0] v);
    @(posedge sys_clk_i);
    evt_i <= sbcio_pkg::sbcio_evt_s'(v);
    @(posedge sys_clk_i);
    evt_i <= '0;
  endtask : ev

  task automatic stop_cmd;
    @(posedge sys_clk_i);
    stop_cmd_i <= 1'b1;
    @(posedge sys_clk_i);
    stop_cmd_i <= 1'b0;
    idle(30);
  endtask : stop_cmd

  task automatic t_reset;
    chk(int_n_o, 1);
    chk(irq_o, 0);
    rdchk(8'h00, 0);
    rdchk(8'h04, 0);
    rdchk(8'h1c, 0);
  endtask : t_reset

  task automatic t_cfg;
    strap <= 1'b1;
    idle(2);
    chk(cfg_o, 0);
    idle(8);
    chk(cfg_o, 1);
    rdchk(8'h14, 3);
    mode_i <= sbcio_pkg::SBCIO_MODE_NORMAL;
    strap <= 1'b0;
    idle(2);
    chk(int_oe_o, 1);
  endtask : t_cfg

  task automatic t_wake;
    n0 = npulse;
    bus(1'b1, 8'h04, 32'h103);
    ev(32'h1);
    idle(30);
    chk(npulse - n0, 1);
    chk(low_len, PW);
    rdchk(8'h08, 32'h1);
    ev(32'h2);
    idle(3);
    ev(32'h100);
    idle(40);
    chk(npulse - n0, 3);
    chk(gap_len, PW);
    rdchk(8'h08, 32'h103);
  endtask : t_wake

  task automatic t_class;
    n0 = npulse;
    level_i <= 16'hff;
    ev(32'h0108_0080);
    idle(30);
    chk(npulse - n0, 0);
    rdchk(8'h20, 32'h0108_0183);
    rdchk(8'h42, 0);
    bus(1'b1, 8'h10, 32'h1234);
    rdchk(8'h10, 32'hff);
    bus(1'b1, 8'h00, 32'h1);
    idle(30);
    chk(npulse - n0, 1);
    rdchk(8'h0c, 32'h108);
    bus(1'b1, 8'h0c, 32'h108);
    ev(32'h0008_0000);
    idle(30);
    chk(npulse - n0, 1);
  endtask : t_class

  task automatic t_stop;
    bus(1'b1, 8'h18, 32'h7);
    bus(1'b1, 8'h1c, 32'h5);
    idle(2);
    chk(irq_o, 0);
    n0 = npulse;
    mode_i <= sbcio_pkg::SBCIO_MODE_STOP;
    stop_cmd;
    chk(npulse - n0, 1);
    chk(irq_o, 1);
    rdchk(8'h18, 32'h5);
    bus(1'b1, 8'h18, 32'h5);
    idle(2);
    chk(irq_o, 0);
    bus(1'b1, 8'h08, 32'hffff);
    rdchk(8'h08, 0);
    stop_cmd;
    chk(npulse - n0, 1);
    bus(1'b1, 8'h1c, 32'h4);
    ev(32'h1);
    idle(30);
    chk(npulse - n0, 2);
    chk(irq_o, 0);
  endtask : t_stop

  initial begin
    idle(2);
    rst_i <= 1'b0;
    t_reset();
    t_cfg();
    t_wake();
    t_class();
    t_stop();
    stop_test();
  end

  // A hang beyond 5000 cycles, some fourteen times the expected run of about 350, counts as a mismatch.
  initial begin
    idle(5000);
    err_total++;
    stop_test();
  end
endmodule : sbcio_int_top_tb
